//--- motor_gate_pkg.sv
// Shared constants and carrier types for the motor gating control.
// Assumes a single 20 MHz system clock; all times become cycle counts here.
package motor_gate_pkg;

	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned PWM_FREQ_HZ     = 18_000;
	localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / PWM_FREQ_HZ;
	localparam int unsigned SOFT_START_S    = 60;
	localparam int unsigned RAMP_STEPS      = 256;
	localparam int unsigned RAMP_STEP_CYC   = (CLK_HZ / RAMP_STEPS) * SOFT_START_S;
	localparam int unsigned LOCK_TIME_MS    = 2000;
	localparam int unsigned LOCK_CYC        = (CLK_HZ / 1000) * LOCK_TIME_MS;
	localparam int unsigned CNT_W           = 32;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_DUTY       = 8'h04;
	localparam logic [7:0] OFS_STATE      = 8'h08;
	localparam logic [7:0] OFS_INT_STATUS = 8'h0C;
	localparam logic [7:0] OFS_INT_MASK   = 8'h10;

	// Control register fields
	localparam int CTRL_EXT_PWM_BIT = 0;
	localparam int CTRL_SOFT_EN_BIT = 1;

	// Event bit positions, shared by status and mask
	localparam int EV_TRIP      = 0;
	localparam int EV_LOCKOUT   = 1;
	localparam int EV_CUR_LIMIT = 2;
	localparam int EV_RAMP_DONE = 3;
	localparam int EV_W         = 4;

	// Reset values
	localparam logic [1:0]      CTRL_RESET = 2'h0;
	localparam logic [7:0]      DUTY_RESET = 8'h00;
	localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

	typedef struct packed {
		logic       ext_pwm;     // External PWM demand
		logic       start_stop;  // Start/stop level
		logic       brake;       // Dynamic brake request
		logic       trip;        // Current trip pulse
		logic       cur_limit;   // Current limit comparator
		logic       hall_edge;   // Rotor position sensor change
		logic [3:0] peak_level;  // Peak current magnitude
	} host_in_s;

	typedef struct packed {
		logic gate;       // Output amplifier enable
		logic brake_on;   // Dynamic brake engaged
		logic cl_led;     // Current limit indicator
		logic fault;      // Locked rotor shutdown
	} drive_out_s;

	typedef enum logic [1:0] {
		ST_STOP,
		ST_RUN,
		ST_LOCKOUT
	} run_state_e;

endpackage

//--- rate_divider.sv
// Cycle counter that emits a one-cycle tick every PERIOD enabled cycles.
// Assumes clear and enable are synchronous to the clock.
`timescale 1ns/10ps
module rate_divider #(
	parameter int unsigned PERIOD = 16
) (
	input  wire logic                               sys_clk, // System clock
	input  wire logic                               rst,     // Sync reset
	input  wire logic                               clear,   // Restart count
	input  wire logic                               enable,  // Count enable
	output logic [motor_gate_pkg::CNT_W-1:0]        count,   // Current count
	output logic                                    tick     // Period end pulse
);
	localparam logic [motor_gate_pkg::CNT_W-1:0] LAST =
		motor_gate_pkg::CNT_W'(PERIOD - 1);

	always_ff @(posedge sys_clk) begin
		if (rst || clear) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (enable) begin
			tick <= (count == LAST);
			if (count == LAST) begin
				count <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end else begin
			tick <= 1'b0;
		end
	end
endmodule // rate_divider

//--- soft_start_ramp.sv
// Acceleration ramp: climbs from zero to full scale one step per tick.
// Assumes restart is pulsed once per start; done holds until next restart.
`timescale 1ns/10ps
module soft_start_ramp (
	input  wire logic       sys_clk, // System clock
	input  wire logic       rst,     // Sync reset
	input  wire logic       restart, // Begin a new ramp
	input  wire logic       step,    // Advance one step
	output logic [7:0]      level,   // Ramp level
	output logic            done     // Ramp has timed out
);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			level <= 8'h00;
			done  <= 1'b0;
		end else if (restart) begin
			level <= 8'h00;
			done  <= 1'b0;
		end else if (step && !done) begin
			// Once done, only restart brings the ramp back
			if (level == 8'hFF) begin
				done <= 1'b1;
			end else begin
				level <= level + 8'h01;
			end
		end
	end
endmodule // soft_start_ramp

//--- bldc_pwm_gating_control.sv
// Gating and run control for a brushless motor drive output stage.
// Assumes host inputs are synchronous to sys_clk and the register port
// is driven by a master that never issues read and write together.
// Operation
// - External PWM high switches amplifier on
// - Current limit overrides external PWM demand
// - Indicator on in current limit, brighter with peak
// - Brake engaged only while brake input high
// - Soft-start ramp begins only on run toggle
// - Completed ramp repeats only after off-on toggle
// - Slowest ramp lasts about sixty seconds
// - Locked rotor shuts output, indicator fully on
// - Lockout held until start/stop toggles on
// - Trip edge kills output until next cycle
// - Reset gives stopped state until toggled
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module bldc_pwm_gating_control #(
	parameter int unsigned RAMP_STEP_CYC = motor_gate_pkg::RAMP_STEP_CYC,
	parameter int unsigned LOCK_CYC      = motor_gate_pkg::LOCK_CYC
) (
	input  wire logic                       sys_clk,  // 20 MHz clock
	input  wire logic                       rst,      // Sync reset, high
	input  wire motor_gate_pkg::host_in_s   host_in,  // Host control inputs
	input  wire logic [7:0]                 addr,     // Register address
	input  wire logic [31:0]                wdata,    // Write data
	input  wire logic                       wr_en,    // Write strobe
	input  wire logic                       rd_en,    // Read strobe
	output motor_gate_pkg::drive_out_s      drive,    // Drive outputs
	output logic [31:0]                     rdata,    // Read data, next cycle
	output logic                            irq       // Interrupt level
);
	localparam int unsigned PWM_PERIOD = motor_gate_pkg::PWM_PERIOD_CYC;

	motor_gate_pkg::run_state_e state_reg;
	motor_gate_pkg::drive_out_s drive_next;

	logic [1:0]                          ctrl_reg;
	logic [7:0]                          duty_reg;
	logic                                ext_mode_reg;
	logic [motor_gate_pkg::EV_W-1:0]     int_status_reg;
	logic [motor_gate_pkg::EV_W-1:0]     int_mask_reg;
	logic [motor_gate_pkg::EV_W-1:0]     events;
	logic                                start_prev_reg;
	logic                                trip_prev_reg;
	logic                                cl_prev_reg;
	logic                                trip_pending_reg;
	logic                                ramp_done_prev_reg;
	logic                                start_rise;
	logic                                start_fall;
	logic                                trip_rise;
	logic                                running;
	logic                                ramp_restart;
	logic [motor_gate_pkg::CNT_W-1:0]    pwm_count;
	logic                                cycle_start;
	logic                                ramp_step;
	logic                                lock_tick;
	logic [7:0]                          ramp_level;
	logic                                ramp_done;
	logic [7:0]                          eff_duty;
	logic [motor_gate_pkg::CNT_W-1:0]    duty_cycles;
	logic                                demand;
	logic [3:0]                          led_phase;
	logic                                rd_status;

	assign start_rise = host_in.start_stop && !start_prev_reg;
	assign start_fall = !host_in.start_stop && start_prev_reg;
	assign trip_rise  = host_in.trip && !trip_prev_reg;
	assign running    = (state_reg == motor_gate_pkg::ST_RUN);
	assign rd_status  = rd_en && (addr == motor_gate_pkg::OFS_INT_STATUS);

	// Internal PWM oscillator: one cycle start pulse per 18 kHz period
	rate_divider #(
		.PERIOD (PWM_PERIOD)
	) u_pwm_osc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (1'b0),
		.enable  (1'b1),
		.count   (pwm_count),
		.tick    (cycle_start)
	);

	// Ramp step timer; 256 steps span the slowest soft-start time
	rate_divider #(
		.PERIOD (RAMP_STEP_CYC)
	) u_ramp_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (ramp_restart),
		.enable  (running),
		.count   (),
		.tick    (ramp_step)
	);

	// Locked-rotor timer: runs while in current limit with no rotor motion.
	// Any sensor change or leaving current limit restarts the count, so
	// only a stall that keeps the limit active ends in lockout.
	rate_divider #(
		.PERIOD (LOCK_CYC)
	) u_lock_timer (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (host_in.hall_edge || !running || !host_in.cur_limit),
		.enable  (1'b1),
		.count   (),
		.tick    (lock_tick)
	);

	soft_start_ramp u_ramp (
		.sys_clk (sys_clk),
		.rst     (rst),
		.restart (ramp_restart),
		.step    (ramp_step),
		.level   (ramp_level),
		.done    (ramp_done)
	);

	// Start history resets high: a start level held through reset is no
	// toggle, the host must drop it and raise it again
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			start_prev_reg <= 1'b1;
		end else begin
			start_prev_reg <= host_in.start_stop;
		end
	end

	// Trip and limit history reset to their idle low level, so reset
	// itself never fakes an edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trip_prev_reg <= 1'b0;
		end else begin
			trip_prev_reg <= host_in.trip;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cl_prev_reg <= 1'b0;
		end else begin
			cl_prev_reg <= host_in.cur_limit;
		end
	end

	// Run state. A start level already high at reset does not count as a
	// toggle: the start history resets high, so only a low-then-high
	// sequence after reset leaves the stopped state.
	// Lockout leaves only on a fresh rise; a fall alone keeps it latched
	// so a stalled rotor is never re-energised by a noisy start line.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg    <= motor_gate_pkg::ST_STOP;
			ramp_restart <= 1'b0;
		end else begin
			ramp_restart <= 1'b0;
			case (state_reg)
				motor_gate_pkg::ST_STOP: begin
					if (start_rise) begin
						state_reg    <= motor_gate_pkg::ST_RUN;
						ramp_restart <= 1'b1;
					end
				end
				motor_gate_pkg::ST_RUN: begin
					if (lock_tick) begin
						state_reg <= motor_gate_pkg::ST_LOCKOUT;
					end else if (start_fall) begin
						state_reg <= motor_gate_pkg::ST_STOP;
					end
				end
				motor_gate_pkg::ST_LOCKOUT: begin
					if (start_rise) begin
						state_reg    <= motor_gate_pkg::ST_RUN;
						ramp_restart <= 1'b1;
					end
				end
				default: begin
					state_reg <= motor_gate_pkg::ST_STOP;
				end
			endcase
		end
	end

	// Trip latch; a new trip edge wins over the cycle-start clear
	// A long trip pulse acts once: only its rising edge sets the latch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trip_pending_reg <= 1'b0;
		end else if (trip_rise) begin
			trip_pending_reg <= 1'b1;
		end else if (cycle_start) begin
			trip_pending_reg <= 1'b0;
		end
	end

	// Source selection follows the control bit only while stopped, so a
	// mid-run change cannot jerk the motor between sources.
	// A select written while running waits for the next stop.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ext_mode_reg <= 1'b0;
		end else if (state_reg == motor_gate_pkg::ST_STOP) begin
			ext_mode_reg <= ctrl_reg[motor_gate_pkg::CTRL_EXT_PWM_BIT];
		end
	end

	// Internal modulation: duty limited by the ramp when soft start is on.
	// The ramp only shapes the internal duty; an external PWM source is
	// passed unramped and must shape its own acceleration.
	always_comb begin
		if (ctrl_reg[motor_gate_pkg::CTRL_SOFT_EN_BIT] && !ramp_done &&
			ramp_level < duty_reg) begin
			eff_duty = ramp_level;
		end else begin
			eff_duty = duty_reg;
		end
		duty_cycles = motor_gate_pkg::CNT_W'((32'(eff_duty) * PWM_PERIOD) >> 8);
		if (ext_mode_reg) begin
			demand = host_in.ext_pwm;
		end else begin
			demand = (pwm_count < duty_cycles);
		end
	end

	assign led_phase = pwm_count[10:7];

	always_comb begin
		drive_next.gate     = demand && running && !trip_pending_reg &&
			!host_in.brake && !host_in.cur_limit && !trip_rise;
		drive_next.brake_on = host_in.brake;
		drive_next.fault    = (state_reg == motor_gate_pkg::ST_LOCKOUT);
		// Brightness tracks peak current by on-time within each PWM cycle
		drive_next.cl_led   = drive_next.fault ||
			(host_in.cur_limit && (host_in.peak_level >= led_phase));
	end

	// Registered so every drive output comes straight from a flop
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			drive <= '0;
		end else begin
			drive <= drive_next;
		end
	end

	// Events for the interrupt status register
	// Each event is a one-cycle pulse, so a held level sets status once
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ramp_done_prev_reg <= 1'b0;
		end else begin
			ramp_done_prev_reg <= ramp_done;
		end
	end

	always_comb begin
		events = '0;
		events[motor_gate_pkg::EV_TRIP]      = trip_rise;
		events[motor_gate_pkg::EV_LOCKOUT]   = lock_tick && running;
		events[motor_gate_pkg::EV_CUR_LIMIT] = host_in.cur_limit && !cl_prev_reg;
		events[motor_gate_pkg::EV_RAMP_DONE] = ramp_done && !ramp_done_prev_reg;
	end

	// Read clears status; an event in the same cycle survives the clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			int_status_reg <= '0;
		end else if (rd_status) begin
			int_status_reg <= events;
		end else begin
			int_status_reg <= int_status_reg | events;
		end
	end

	// Interrupt lags status by one cycle and drops the cycle after a clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_reg & int_mask_reg);
		end
	end

	// Register writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg     <= motor_gate_pkg::CTRL_RESET;
			duty_reg     <= motor_gate_pkg::DUTY_RESET;
			int_mask_reg <= motor_gate_pkg::MASK_RESET;
		end else if (wr_en) begin
			case (addr)
				motor_gate_pkg::OFS_CTRL: begin
					ctrl_reg <= wdata[1:0];
				end
				motor_gate_pkg::OFS_DUTY: begin
					duty_reg <= wdata[7:0];
				end
				motor_gate_pkg::OFS_INT_MASK: begin
					int_mask_reg <= wdata[motor_gate_pkg::EV_W-1:0];
				end
				// Read-only and unmapped offsets ignore writes
				default: begin
				end
			endcase
		end
	end

	// Register reads; data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (addr)
				motor_gate_pkg::OFS_CTRL: begin
					rdata <= {30'h0, ctrl_reg};
				end
				motor_gate_pkg::OFS_DUTY: begin
					rdata <= {24'h0, duty_reg};
				end
				motor_gate_pkg::OFS_STATE: begin
					rdata <= {16'h0, ramp_level, ramp_done, ext_mode_reg,
						trip_pending_reg, host_in.cur_limit, drive.brake_on,
						state_reg, running};
				end
				motor_gate_pkg::OFS_INT_STATUS: begin
					rdata <= {28'h0, int_status_reg};
				end
				motor_gate_pkg::OFS_INT_MASK: begin
					rdata <= {28'h0, int_mask_reg};
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule // bldc_pwm_gating_control

//--- gate_assertions.sv
// Port checker for the motor gating control.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/10ps
module gate_assertions (
	input wire logic                       sys_clk, // Clock
	input wire logic                       rst,     // Reset
	input wire motor_gate_pkg::host_in_s   host_in, // Host inputs
	input wire motor_gate_pkg::drive_out_s drive    // Drive outputs
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic ss_reg;
	logic go_reg;
	// Tracks the level held in reset, since a level high then is no start
	always_ff @(posedge sys_clk) begin
		ss_reg <= host_in.start_stop;
	end
	always_ff @(posedge sys_clk) begin
		if (rst)
			go_reg <= 1'b0;
		else if (host_in.start_stop && !ss_reg)
			go_reg <= 1'b1;
	end
	AST_NO_RUN: assert property (!go_reg |-> !drive.gate)
		else $error("gate on before first start");
	AST_BRAKE_ON: assert property (host_in.brake |=> drive.brake_on && !drive.gate)
		else $error("brake request not applied");
	AST_BRAKE_OFF: assert property (!host_in.brake |=> !drive.brake_on)
		else $error("brake on without request");
	AST_CL_GATE: assert property (host_in.cur_limit |=> !drive.gate)
		else $error("gate on in current limit");
	AST_CL_LED: assert property (
		host_in.cur_limit && host_in.peak_level == 4'hF |=> drive.cl_led)
		else $error("indicator off at full peak");
	AST_TRIP_KILL: assert property ($rose(host_in.trip) |=> !drive.gate)
		else $error("gate on after trip edge");
	AST_FAULT_HOLD: assert property ($rose(drive.fault) |=> drive.fault [*8])
		else $error("lockout dropped early");
	AST_FAULT_OUT: assert property (
		drive.fault ##1 drive.fault |-> !drive.gate && drive.cl_led)
		else $error("lockout outputs wrong");
	cover property ($rose(drive.fault));
	cover property (host_in.brake ##1 drive.brake_on);
	cover property ($rose(host_in.trip));
endmodule // gate_assertions

bind bldc_pwm_gating_control gate_assertions u_gate_assertions (
	.sys_clk(sys_clk), .rst(rst), .host_in(host_in), .drive(drive));

//--- host_model.sv
// Host controller model driving the logic-level control inputs.
// Assumes the testbench calls its tasks and sets spin between edges.
`timescale 1ns/10ps
module host_model (
	input  wire logic                sys_clk, // Clock
	output motor_gate_pkg::host_in_s host_in  // Control inputs
);
	logic       spin;
	logic [3:0] ph;
	initial begin
		host_in = '0;
		spin = 1'b1;
		ph = 4'h0;
	end
	// A turning rotor gives a sensor change every 16 cycles, a locked one none
	always @(posedge sys_clk) begin
		ph <= ph + 4'h1;
		host_in.hall_edge <= spin && (ph == 4'hF);
	end
	// Levels change a few cycles apart, well above a 20 kHz rate; brake kept short
	task automatic drv(input logic pwm, input logic brk, input logic cl);
		@(posedge sys_clk);
		host_in.ext_pwm <= pwm;
		host_in.brake <= brk;
		host_in.cur_limit <= cl;
		host_in.peak_level <= {4{cl}};
	endtask
	task automatic start();
		@(posedge sys_clk);
		host_in.brake <= 1'b0;
		host_in.start_stop <= 1'b0;
		repeat (3) @(posedge sys_clk);
		host_in.start_stop <= 1'b1;
	endtask
	// 60 cycles is 3 us, inside the allowed pulse width
	task automatic trip();
		@(posedge sys_clk);
		host_in.trip <= 1'b1;
		repeat (60) @(posedge sys_clk);
		host_in.trip <= 1'b0;
	endtask
endmodule // host_model

//--- tb_bldc_pwm_gating_control.sv
// Testbench for the motor gating control: register port and host inputs.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_bldc_pwm_gating_control;
	logic                       sys_clk;
	logic                       rst;
	motor_gate_pkg::host_in_s   host_in;
	logic [7:0]                 addr;
	logic [31:0]                wdata;
	logic                       wr_en;
	logic                       rd_en;
	motor_gate_pkg::drive_out_s drive;
	logic [31:0]                rdata;
	logic                       irq;
	logic [31:0]                rv;
	logic [7:0]                 map_a [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h40};
	int                         err_total = 0;
	int                         n_tests = 0;
	int                         cyc = 0;
	int                         n;

	// Short ramp and lock counts keep the run brief
	bldc_pwm_gating_control #(.RAMP_STEP_CYC(4), .LOCK_CYC(50)) u_bldc_pwm_gating_control (
		.sys_clk(sys_clk), .rst(rst), .host_in(host_in), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .drive(drive), .rdata(rdata), .irq(irq));
	host_model u_host_model (.sys_clk(sys_clk), .host_in(host_in));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		rv = rdata;
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (map_a[i]) begin
			rd(map_a[i]);
			check(rv, 32'h0);
		end
		check(32'(drive), 32'h0);
		done("reset");
		wr(8'h00, 32'h1);
		wr(8'h10, 32'h7);
		u_host_model.drv(1'b1, 1'b0, 1'b0);
		wt(3);
		check(32'(drive.gate), 32'h0);
		u_host_model.start();
		wt(2);
		check(32'(drive.gate), 32'h1);
		rd(8'h08);
		check(rv & 32'h7F, 32'h43);
		u_host_model.drv(1'b0, 1'b0, 1'b0);
		wt(2);
		check(32'(drive.gate), 32'h0);
		done("external pwm");
		u_host_model.drv(1'b1, 1'b1, 1'b0);
		wt(2);
		check(32'({drive.brake_on, drive.gate}), 32'h2);
		u_host_model.drv(1'b1, 1'b0, 1'b0);
		wt(2);
		check(32'({drive.brake_on, drive.gate}), 32'h1);
		done("brake");
		u_host_model.drv(1'b1, 1'b0, 1'b1);
		wt(3);
		check(32'({drive.cl_led, drive.gate, irq}), 32'h5);
		u_host_model.drv(1'b1, 1'b0, 1'b0);
		rd(8'h0C);
		check(rv, 32'h4);
		wt(1);
		check(32'({drive.gate, irq}), 32'h2);
		done("current limit");
		wr(8'h10, 32'h0);
		fork
			u_host_model.trip();
			begin
				wt(3);
				check(32'({drive.gate, irq}), 32'h0);
			end
		join
		n = 0;
		while (drive.gate !== 1'b1 && n < 1060) begin
			wt(1);
			n++;
		end
		check(32'(drive.gate), 32'h1);
		wr(8'h10, 32'h1);
		wt(2);
		check(32'(irq), 32'h1);
		rd(8'h0C);
		check(rv & 32'h7, 32'h1);
		wt(1);
		check(32'(irq), 32'h0);
		done("trip");
		u_host_model.spin = 1'b0;
		u_host_model.drv(1'b1, 1'b0, 1'b1);
		n = 0;
		while (drive.fault !== 1'b1 && n < 60) begin
			wt(1);
			n++;
		end
		check(32'({drive.fault, drive.cl_led, drive.gate}), 32'h6);
		u_host_model.drv(1'b1, 1'b0, 1'b0);
		wt(20);
		rd(8'h08);
		check(32'({drive.fault, drive.cl_led, rv[2:0]}), 32'h1C);
		u_host_model.spin = 1'b1;
		u_host_model.start();
		wt(2);
		check(32'({drive.fault, drive.gate}), 32'h1);
		done("lockout");
		@(posedge sys_clk);
		u_host_model.host_in.start_stop <= 1'b0;
		wr(8'h00, 32'h2);
		wr(8'h04, 32'hFF);
		u_host_model.start();
		wt(8);
		rd(8'h08);
		check(32'(rv[7]), 32'h0);
		wt(1100);
		rd(8'h08);
		check(32'({rv[15:8], rv[7]}), 32'h1FF);
		u_host_model.start();
		wt(8);
		rd(8'h08);
		check(32'(rv[7]), 32'h0);
		done("soft start");
		// Reset in mid-run with start held high must leave the motor stopped
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		wt(3);
		rd(8'h08);
		check(rv & 32'h7, 32'h0);
		check(32'(drive), 32'h0);
		done("mid-run reset");
		end_of_test();
	end
endmodule // tb_bldc_pwm_gating_control
